/* rec_loop_match.sv */
module rec_loop_match #(
    parameter int          CNT_W = 8,
    parameter logic [7:0]  INTEG = 8'(rec_pkg::INTEG_BITS)
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic [15:0] pattern,
    input  wire logic [3:0]  len_m1,
    input  wire logic        restart,
    input  wire logic        line_bit,
    input  wire logic        line_bit_en,
    output logic             detected
);
    typedef struct packed {
        logic [3:0]       phase;
        logic [CNT_W-1:0] count;
        logic             det;
    } rec_match_type;

    rec_match_type s;
    rec_match_type n;

    always_comb begin
        n = s;
        if (restart) begin
            n = '0;
        end else if (line_bit_en) begin
            // only phases up to len_m1 are compared, except after len_m1 is lowered below the current phase
            if (line_bit == pattern[4'hF - s.phase]) begin
                n.phase = (s.phase == len_m1) ? 4'h0 : 4'(s.phase + 4'h1);
                if (s.count < CNT_W'(INTEG)) begin
                    n.count = CNT_W'(s.count + 1'b1);
                end
            end else if (line_bit == pattern[15]) begin
                // resync on the first pattern bit instead of losing a whole period
                n.phase = (len_m1 == 4'h0) ? 4'h0 : 4'h1;
                n.count = CNT_W'(1);
            end else begin
                n.phase = 4'h0;
                n.count = '0;
            end
        end
        n.det = (n.count >= CNT_W'(INTEG));
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign detected = s.det;
endmodule // rec_loop_match

/* rec_pkg.sv */
package rec_pkg;
    // ----------------------------------------------------------------
    // geometry
    // ----------------------------------------------------------------
    localparam int         NUM_PORTS    = 8;
    localparam int         NUM_CHANS    = 32;
    localparam int         SA_BITS      = 5;
    localparam int         PORT_LSB     = 9;      // index stride 200h per port
    localparam int         NUM_RW_SLOTS = 12;
    localparam int         INTEG_BITS   = 32;     // loop code integration, in line bits
    // ----------------------------------------------------------------
    // register indexes within one port (byte address = 4 * index)
    // ----------------------------------------------------------------
    localparam logic [8:0] IDX_SA_IRQ_EN  = 9'h0A6;
    localparam logic [8:0] IDX_SIG_EN1    = 9'h0A8;
    localparam logic [8:0] IDX_SIG_EN2    = 9'h0A9;
    localparam logic [8:0] IDX_SIG_EN3    = 9'h0AA;
    localparam logic [8:0] IDX_SIG_EN4    = 9'h0AB;
    localparam logic [8:0] IDX_UP_FIRST   = 9'h0AC;
    localparam logic [8:0] IDX_UP_SECOND  = 9'h0AD;
    localparam logic [8:0] IDX_DN_FIRST   = 9'h0AE;
    localparam logic [8:0] IDX_DN_SECOND  = 9'h0AF;
    localparam logic [8:0] IDX_CTRL       = 9'h0F0;
    localparam logic [8:0] IDX_EVT_MASK   = 9'h0F1;
    localparam logic [8:0] IDX_SA_MASK    = 9'h0F2;
    localparam logic [8:0] IDX_EVT_STATUS = 9'h0F3;
    localparam logic [8:0] IDX_RT_STATUS  = 9'h0F4;
    // ----------------------------------------------------------------
    // storage slots
    // ----------------------------------------------------------------
    localparam logic [3:0] SLOT_SA_IRQ_EN  = 4'h0;
    localparam logic [3:0] SLOT_SIG_EN1    = 4'h1;
    localparam logic [3:0] SLOT_SIG_EN2    = 4'h2;
    localparam logic [3:0] SLOT_SIG_EN3    = 4'h3;
    localparam logic [3:0] SLOT_SIG_EN4    = 4'h4;
    localparam logic [3:0] SLOT_UP_FIRST   = 4'h5;
    localparam logic [3:0] SLOT_UP_SECOND  = 4'h6;
    localparam logic [3:0] SLOT_DN_FIRST   = 4'h7;
    localparam logic [3:0] SLOT_DN_SECOND  = 4'h8;
    localparam logic [3:0] SLOT_CTRL       = 4'h9;
    localparam logic [3:0] SLOT_EVT_MASK   = 4'hA;
    localparam logic [3:0] SLOT_SA_MASK    = 4'hB;
    localparam logic [3:0] SLOT_EVT_STATUS = 4'hC;
    localparam logic [3:0] SLOT_RT_STATUS  = 4'hD;
    // ----------------------------------------------------------------
    // fields, masks, reset
    // ----------------------------------------------------------------
    localparam int         BIT_BD_SAX  = 0;
    localparam int         BIT_SA6     = 1;
    localparam int         BIT_SIG     = 3;
    localparam int         BIT_LUP     = 4;
    localparam int         BIT_LDN     = 5;
    localparam int         BIT_E1      = 0;
    localparam int         LEN_LSB     = 4;
    localparam logic [7:0] REG_RESET   = 8'h00;
    localparam logic [7:0] CTRL_WMASK  = 8'hF1;
    localparam logic [7:0] EMASK_WMASK = 8'h38;
    localparam logic [7:0] SAM_WMASK   = 8'h1F;
    localparam logic [7:0] W1C_MASK    = 8'h3B;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* rec_rx_event_regs.sv */
// Register access over AXI4-Lite was decided locally.
module rec_rx_event_regs #(
    parameter int ADDR_W = 16
) (
    input  wire logic              clk,
    input  wire logic              reset_n,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic [7:0]        rx_line_bit,
    input  wire logic [7:0]        rx_line_bit_en,
    input  wire logic [255:0]      sig_change_strobe,
    input  wire logic [7:0]        boc_detect_evt,
    input  wire logic [7:0]        sa6_codeword_evt,
    input  wire logic [39:0]       sax_bits,
    output wire logic [7:0]        loop_up_condition,
    output wire logic [7:0]        loop_down_condition,
    output logic                   irq
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        WR_COLLECT = 2'b01,
        WR_RESP    = 2'b10
    } rec_wr_type;

    typedef struct packed {
        logic [7:0][11:0][7:0] cfg;
        logic [7:0][7:0]       status;
        logic [7:0][4:0]       sax_prev;
        logic [7:0]            lup_prev;
        logic [7:0]            ldn_prev;
        rec_wr_type            wr;
        logic                  aw_held;
        logic                  w_held;
        logic [ADDR_W-1:0]     awaddr;
        logic [7:0]            wdata;
        logic                  wstrb0;
        logic [1:0]            bresp;
        logic                  rvalid;
        logic [7:0]            rdata;
        logic [1:0]            rresp;
    } rec_state_type;

    localparam rec_state_type ST_RESET = '{
        cfg: {rec_pkg::NUM_PORTS * rec_pkg::NUM_RW_SLOTS{rec_pkg::REG_RESET}},
        wr: WR_COLLECT,
        default: '0
    };

    rec_state_type st;
    rec_state_type nx;

    logic [7:0]           restart_up;
    logic [7:0]           restart_dn;
    wire logic [7:0][7:0] irq_en;

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    // returns {mapped, slot}; port lives in the bits above the offset
    function automatic logic [4:0] decode(input logic [ADDR_W-1:0] a);
        logic [8:0] off;
        logic [3:0] slot;
        logic       hit;
        off  = a[rec_pkg::PORT_LSB+1:2];
        hit  = 1'b1;
        case (off)
            rec_pkg::IDX_SA_IRQ_EN:  slot = rec_pkg::SLOT_SA_IRQ_EN;
            rec_pkg::IDX_SIG_EN1:    slot = rec_pkg::SLOT_SIG_EN1;
            rec_pkg::IDX_SIG_EN2:    slot = rec_pkg::SLOT_SIG_EN2;
            rec_pkg::IDX_SIG_EN3:    slot = rec_pkg::SLOT_SIG_EN3;
            rec_pkg::IDX_SIG_EN4:    slot = rec_pkg::SLOT_SIG_EN4;
            rec_pkg::IDX_UP_FIRST:   slot = rec_pkg::SLOT_UP_FIRST;
            rec_pkg::IDX_UP_SECOND:  slot = rec_pkg::SLOT_UP_SECOND;
            rec_pkg::IDX_DN_FIRST:   slot = rec_pkg::SLOT_DN_FIRST;
            rec_pkg::IDX_DN_SECOND:  slot = rec_pkg::SLOT_DN_SECOND;
            rec_pkg::IDX_CTRL:       slot = rec_pkg::SLOT_CTRL;
            rec_pkg::IDX_EVT_MASK:   slot = rec_pkg::SLOT_EVT_MASK;
            rec_pkg::IDX_SA_MASK:    slot = rec_pkg::SLOT_SA_MASK;
            rec_pkg::IDX_EVT_STATUS: slot = rec_pkg::SLOT_EVT_STATUS;
            rec_pkg::IDX_RT_STATUS:  slot = rec_pkg::SLOT_RT_STATUS;
            default: begin
                slot = 4'h0;
                hit  = 1'b0;
            end
        endcase
        // only word-aligned accesses to ports 0..7 hit
        if (a[1:0] != 2'h0 || a[ADDR_W-1:rec_pkg::PORT_LSB+5] != '0) begin
            hit = 1'b0;
        end
        return {hit, slot};
    endfunction

    function automatic logic [7:0] wmask(input logic [3:0] slot);
        case (slot)
            rec_pkg::SLOT_CTRL:     return rec_pkg::CTRL_WMASK;
            rec_pkg::SLOT_EVT_MASK: return rec_pkg::EMASK_WMASK;
            rec_pkg::SLOT_SA_MASK:  return rec_pkg::SAM_WMASK;
            default:                return 8'hFF;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [4:0]  wdec;
        logic [4:0]  rdec;
        logic [2:0]  wport;
        logic [2:0]  rport;
        logic        wr_go;
        logic        e1;
        logic [31:0] sig_en;
        logic        sax_chg;
        logic [7:0]  set;
        logic [7:0]  clr;
        logic        wr_here;
        nx         = st;
        restart_up = '0;
        restart_dn = '0;
        wdec       = '0;
        rdec       = '0;
        wport      = '0;
        rport      = '0;
        wr_go      = 1'b0;
        e1         = 1'b0;
        sig_en     = '0;
        sax_chg    = 1'b0;
        set        = '0;
        clr        = '0;
        wr_here    = 1'b0;

        // write channels, taken in either order
        if (s_axi_awvalid && s_axi_awready) begin
            nx.aw_held = 1'b1;
            nx.awaddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            nx.w_held  = 1'b1;
            nx.wdata   = s_axi_wdata[7:0];
            nx.wstrb0  = s_axi_wstrb[0];
        end
        case (st.wr)
            WR_COLLECT: begin
                if (nx.aw_held && nx.w_held) begin
                    wr_go      = 1'b1;
                    wdec       = decode(nx.awaddr);
                    wport      = nx.awaddr[rec_pkg::PORT_LSB+4:rec_pkg::PORT_LSB+2];
                    nx.bresp   = wdec[4] ? rec_pkg::RESP_OKAY : rec_pkg::RESP_SLVERR;
                    nx.aw_held = 1'b0;
                    nx.w_held  = 1'b0;
                    nx.wr      = WR_RESP;
                end
            end
            WR_RESP: begin
                if (s_axi_bready) begin
                    nx.wr = WR_COLLECT;
                end
            end
            default: nx.wr = WR_COLLECT;
        endcase

        for (int p = 0; p < rec_pkg::NUM_PORTS; p++) begin
            e1      = st.cfg[p][rec_pkg::SLOT_CTRL][rec_pkg::BIT_E1];
            wr_here = wr_go && wdec[4] && nx.wstrb0 && (wport == 3'(p));
            // channels 25..32 only exist on an E1 line
            sig_en  = {st.cfg[p][rec_pkg::SLOT_SIG_EN4] & {8{e1}},
                       st.cfg[p][rec_pkg::SLOT_SIG_EN3],
                       st.cfg[p][rec_pkg::SLOT_SIG_EN2],
                       st.cfg[p][rec_pkg::SLOT_SIG_EN1]};
            sax_chg = |((sax_bits[p*rec_pkg::SA_BITS +: rec_pkg::SA_BITS] ^ st.sax_prev[p])
                        & ~st.cfg[p][rec_pkg::SLOT_SA_MASK][4:0]);
            nx.sax_prev[p] = sax_bits[p*rec_pkg::SA_BITS +: rec_pkg::SA_BITS];
            nx.lup_prev[p] = loop_up_condition[p];
            nx.ldn_prev[p] = loop_down_condition[p];

            set = '0;
            set[rec_pkg::BIT_BD_SAX] = e1 ? sax_chg : boc_detect_evt[p];
            set[rec_pkg::BIT_SA6]    = e1 && sa6_codeword_evt[p];
            set[rec_pkg::BIT_SIG]    = |(sig_change_strobe[p*rec_pkg::NUM_CHANS +: rec_pkg::NUM_CHANS]
                                         & sig_en);
            set[rec_pkg::BIT_LUP]    = loop_up_condition[p] && !st.lup_prev[p];
            set[rec_pkg::BIT_LDN]    = loop_down_condition[p] && !st.ldn_prev[p];
            clr = (wr_here && wdec[3:0] == rec_pkg::SLOT_EVT_STATUS) ? (nx.wdata & rec_pkg::W1C_MASK) : 8'h00;
            // a new event in the clearing cycle survives the clear
            nx.status[p] = (st.status[p] & ~clr) | set;

            if (wr_here && wdec[3:0] < 4'(rec_pkg::NUM_RW_SLOTS)) begin
                nx.cfg[p][wdec[3:0]] = nx.wdata & wmask(wdec[3:0]);
                restart_up[p] = (wdec[3:0] == rec_pkg::SLOT_UP_FIRST);
                restart_dn[p] = (wdec[3:0] == rec_pkg::SLOT_DN_FIRST);
            end
        end

        // read channel: one outstanding read, answer next cycle
        if (st.rvalid && s_axi_rready) begin
            nx.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rdec      = decode(s_axi_araddr);
            rport     = s_axi_araddr[rec_pkg::PORT_LSB+4:rec_pkg::PORT_LSB+2];
            nx.rvalid = 1'b1;
            nx.rresp  = rdec[4] ? rec_pkg::RESP_OKAY : rec_pkg::RESP_SLVERR;
            if (!rdec[4]) begin
                nx.rdata = 8'h00;
            end else if (rdec[3:0] == rec_pkg::SLOT_EVT_STATUS) begin
                nx.rdata = st.status[rport];
            end else if (rdec[3:0] == rec_pkg::SLOT_RT_STATUS) begin
                nx.rdata = {6'h00, loop_down_condition[rport], loop_up_condition[rport]};
            end else begin
                nx.rdata = st.cfg[rport][rdec[3:0]];
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= ST_RESET;
        end else begin
            st <= nx;
        end
    end

    // ----------------------------------------------------------------
    // loop code detectors
    // ----------------------------------------------------------------
    for (genvar g = 0; g < rec_pkg::NUM_PORTS; g++) begin : g_port
        // first register MSB leads; unused tail bits are compared only after a CTRL write cuts the length below the current phase
        rec_loop_match u_up (
            .clk         (clk),
            .reset_n     (reset_n),
            .pattern     ({st.cfg[g][rec_pkg::SLOT_UP_FIRST], st.cfg[g][rec_pkg::SLOT_UP_SECOND]}),
            .len_m1      (st.cfg[g][rec_pkg::SLOT_CTRL][7:rec_pkg::LEN_LSB]),
            .restart     (restart_up[g]),
            .line_bit    (rx_line_bit[g]),
            .line_bit_en (rx_line_bit_en[g]),
            .detected    (loop_up_condition[g])
        );
        rec_loop_match u_dn (
            .clk         (clk),
            .reset_n     (reset_n),
            .pattern     ({st.cfg[g][rec_pkg::SLOT_DN_FIRST], st.cfg[g][rec_pkg::SLOT_DN_SECOND]}),
            .len_m1      (st.cfg[g][rec_pkg::SLOT_CTRL][7:rec_pkg::LEN_LSB]),
            .restart     (restart_dn[g]),
            .line_bit    (rx_line_bit[g]),
            .line_bit_en (rx_line_bit_en[g]),
            .detected    (loop_down_condition[g])
        );
        // T1 has no Sa6 source, so bit 1 only counts on E1
        assign irq_en[g] = {st.cfg[g][rec_pkg::SLOT_EVT_MASK][7:2],
                            st.cfg[g][rec_pkg::SLOT_SA_IRQ_EN][1]
                            & st.cfg[g][rec_pkg::SLOT_CTRL][rec_pkg::BIT_E1],
                            st.cfg[g][rec_pkg::SLOT_SA_IRQ_EN][0]};
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign irq           = |(st.status & irq_en);
    assign s_axi_awready = (st.wr == WR_COLLECT) && !st.aw_held;
    assign s_axi_wready  = (st.wr == WR_COLLECT) && !st.w_held;
    assign s_axi_bvalid  = (st.wr == WR_RESP);
    assign s_axi_bresp   = st.bresp;
    assign s_axi_arready = !st.rvalid;
    assign s_axi_rvalid  = st.rvalid;
    assign s_axi_rdata   = {24'h000000, st.rdata};
    assign s_axi_rresp   = st.rresp;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence wr_both_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence

    sequence up_first_write;
        wr_both_taken ##0 (s_axi_awaddr == ADDR_W'({rec_pkg::IDX_UP_FIRST, 2'h0})) && s_axi_wstrb[0];
    endsequence

    write_answer_a: assert property (wr_both_taken |=> s_axi_bvalid)
        else $error("write not answered next cycle");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read not answered next cycle");
    up_restart_a: assert property (up_first_write |=> !loop_up_condition[0])
        else $error("loop-up detector not restarted by pattern write");
    sig_event_a: assert property (sig_change_strobe[0] && st.cfg[0][rec_pkg::SLOT_SIG_EN1][0]
                                  |=> st.status[0][rec_pkg::BIT_SIG])
        else $error("enabled channel change did not set flag");
    t1_ch25_a: assert property (!st.cfg[0][rec_pkg::SLOT_CTRL][rec_pkg::BIT_E1]
                                && sig_change_strobe[31:0] == 32'h01000000 && !st.status[0][rec_pkg::BIT_SIG]
                                |=> !st.status[0][rec_pkg::BIT_SIG])
        else $error("channel 25 raised flag in T1 mode");
    sa6_mode_a: assert property (!st.cfg[0][rec_pkg::SLOT_CTRL][rec_pkg::BIT_E1]
                                 && !st.status[0][rec_pkg::BIT_SA6] |=> !st.status[0][rec_pkg::BIT_SA6])
        else $error("Sa6 event latched in T1 mode");
    sig_irq_a: assert property (st.status[0][rec_pkg::BIT_SIG] && st.cfg[0][rec_pkg::SLOT_EVT_MASK][rec_pkg::BIT_SIG]
                                |-> irq)
        else $error("enabled change event did not raise irq");
    bd_irq_a: assert property (st.status == '0 |-> !irq)
        else $error("irq without a pending event");
    reset_zero_a: assert property ($rose(reset_n) |-> st.cfg == '0 && st.status == '0)
        else $error("registers not zero after reset");
    sax_mask_a: assert property (st.cfg[2][rec_pkg::SLOT_SA_MASK][4:0] == 5'h1F && !boc_detect_evt[2]
                                 && !st.status[2][rec_pkg::BIT_BD_SAX] |=> !st.status[2][rec_pkg::BIT_BD_SAX])
        else $error("masked SaX change raised event");
endmodule // rec_rx_event_regs

/* rec_rx_event_regs_bench.sv */
module rec_rx_event_regs_bench;
    timeunit 1ns;
    timeprecision 100ps;
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin bad_count++; \
    $display("[ERR] %0t got %h exp %h", $time, a, e); end end
    logic         clk, reset_n, awvalid, wvalid, bready, arvalid, rready;
    logic         awready, wready, bvalid, arready, rvalid, irq;
    logic [15:0]  awaddr, araddr;
    logic [31:0]  wdata, rdata, rv;
    logic [3:0]   wstrb;
    logic [1:0]   bresp, rresp, rsp;
    logic [7:0]   line_bit, line_en, boc_evt, sa6_evt, up_cond, dn_cond;
    logic [255:0] sig_strobe;
    logic [39:0]  sax;
    logic [8:0]   ix;
    int           bad_count, total_checks;

    rec_rx_event_regs dut_u (.clk(clk), .reset_n(reset_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rx_line_bit(line_bit),
        .rx_line_bit_en(line_en), .sig_change_strobe(sig_strobe), .boc_detect_evt(boc_evt),
        .sa6_codeword_evt(sa6_evt), .sax_bits(sax), .loop_up_condition(up_cond),
        .loop_down_condition(dn_cond), .irq(irq));

    function automatic logic [15:0] adr(input int p, input logic [8:0] i);
        return 16'(4 * (int'(i) + 512 * p));
    endfunction

    // ready is looked at on the falling edge so the handshake edge is known without a race
    task automatic wr(input int p, input logic [8:0] i, input logic [7:0] d);
        logic ta, tw, tb;
        @(posedge clk);
        awaddr <= adr(p, i);
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge clk);
            ta = awready;
            tw = wready;
            tb = bvalid;
            rsp = bresp;
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end while (!tb);
        bready <= 1'b0;
        @(negedge clk);
    endtask

    task automatic rchk(input int p, input logic [8:0] i, input logic [7:0] e,
                        input logic [1:0] er = rec_pkg::RESP_OKAY);
        logic ta, tb;
        @(posedge clk);
        araddr <= adr(p, i);
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge clk);
            ta = arready;
            tb = rvalid;
            rv = rdata;
            rsp = rresp;
            @(posedge clk);
            if (ta) arvalid <= 1'b0;
        end while (!tb);
        rready <= 1'b0;
        `CHK(rv, {24'h000000, e})
        `CHK(rsp, er)
    endtask

    task automatic kick(input logic [255:0] s, input logic [7:0] bd, input logic [7:0] sa6);
        @(posedge clk);
        sig_strobe <= s;
        boc_evt <= bd;
        sa6_evt <= sa6;
        @(posedge clk);
        sig_strobe <= '0;
        boc_evt <= 8'h00;
        sa6_evt <= 8'h00;
        @(negedge clk);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        #50000;
        bad_count++;
        tally_and_finish();
    end

    initial begin
        {reset_n, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, line_bit, line_en, boc_evt, sa6_evt, sig_strobe, sax} = '0;
        wstrb = 4'h1;
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        for (int k = 0; k < 9; k++) begin
            ix = (k == 0) ? 9'h0A6 : 9'(9'h0A7 + k);
            rchk(3, ix, 8'h00);
            wr(3, ix, 8'(8'h5A ^ k));
            rchk(3, ix, 8'(8'h5A ^ k));
            rchk(2, ix, 8'h00);
        end
        wr(0, 9'h0A7, 8'hFF);
        `CHK(rsp, rec_pkg::RESP_SLVERR)
        rchk(0, 9'h0A7, 8'h00, rec_pkg::RESP_SLVERR);
        wr(2, 9'h0A6, 8'h01);
        kick('0, 8'h04, 8'h00);
        `CHK(irq, 1'b1)
        wr(2, 9'h0A6, 8'h00);
        `CHK(irq, 1'b0)
        rchk(2, 9'h0F3, 8'h01);
        wr(2, 9'h0F3, 8'h01);
        wr(2, 9'h0A6, 8'h03);
        kick('0, 8'h00, 8'h04);
        `CHK(irq, 1'b0)
        wr(2, 9'h0F0, 8'h01);
        kick('0, 8'h00, 8'h04);
        `CHK(irq, 1'b1)
        wr(2, 9'h0F3, 8'h02);
        `CHK(irq, 1'b0)
        wr(2, 9'h0F2, 8'h1E);
        @(posedge clk) sax <= 40'h0000000800;
        kick('0, 8'h00, 8'h00);
        `CHK(irq, 1'b0)
        @(posedge clk) sax <= 40'h0000000C00;
        kick('0, 8'h00, 8'h00);
        `CHK(irq, 1'b1)
        wr(2, 9'h0F3, 8'h01);
        wr(2, 9'h0F2, 8'h1F);
        @(posedge clk) sax <= 40'h0000000000;
        kick('0, 8'h00, 8'h00);
        rchk(2, 9'h0F3, 8'h00);
        wr(2, 9'h0A9, 8'h01);
        wr(2, 9'h0F1, 8'h08);
        kick(256'(1) << 73, 8'h00, 8'h00);
        `CHK(irq, 1'b0)
        kick(256'(1) << 72, 8'h00, 8'h00);
        `CHK(irq, 1'b1)
        rchk(2, 9'h0F3, 8'h08);
        // port 0 on T1: channel 25 is dead, channel 1 latches
        wr(0, 9'h0AB, 8'h01);
        kick(256'(1) << 24, 8'h00, 8'h00);
        rchk(0, 9'h0F3, 8'h00);
        wr(0, 9'h0A8, 8'h01);
        wr(0, 9'h0F1, 8'h08);
        kick(256'(1), 8'h00, 8'h00);
        rchk(0, 9'h0F3, 8'h08);
        wr(0, 9'h0F3, 8'h08);
        // four-bit code 1010; low bits and second registers must not matter
        wr(0, 9'h0F0, 8'h30);
        wr(0, 9'h0AC, 8'hA5);
        wr(0, 9'h0AD, 8'hFF);
        wr(0, 9'h0AE, 8'hA5);
        wr(0, 9'h0AF, 8'h00);
        for (int k = 0; k < 40; k++) begin
            @(posedge clk);
            line_bit <= {7'h00, ~k[0]};
            line_en <= 8'h01;
        end
        @(posedge clk) line_en <= 8'h00;
        @(negedge clk);
        `CHK(up_cond, 8'h01)
        `CHK(dn_cond, 8'h01)
        rchk(0, 9'h0F3, 8'h30);
        rchk(0, 9'h0F4, 8'h03);
        wr(0, 9'h0AE, 8'hA5);
        `CHK(dn_cond, 8'h00)
        `CHK(up_cond, 8'h01)
        wr(0, 9'h0AC, 8'hA5);
        `CHK(up_cond, 8'h00)
        // a write with byte lane 0 off must leave the register alone
        @(posedge clk) wstrb <= 4'h0;
        wr(0, 9'h0F0, 8'h00);
        `CHK(rsp, rec_pkg::RESP_OKAY)
        @(posedge clk) wstrb <= 4'h1;
        rchk(0, 9'h0F0, 8'h30);
        // reset again in mid-run: everything back to zero
        @(posedge clk) reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        rchk(2, 9'h0A9, 8'h00);
        rchk(0, 9'h0F0, 8'h00);
        `CHK(irq, 1'b0)
        tally_and_finish();
    end
endmodule // rec_rx_event_regs_bench
